// >>> rtl/ext_mem_pkg.sv
// ****************************************************************
// Shared constants, types and decoders of the external memory port.
// ****************************************************************
package ext_mem_pkg;
  // Register byte addresses on the plain register port.
  localparam logic [7:0] ADDR_CONFIG = 8'h00;
  localparam logic [7:0] ADDR_TIMING = 8'h04;
  localparam logic [7:0] ADDR_BANK = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  // Reset values: timing starts at the longest delays.
  localparam logic [7:0] CONFIG_RST = 8'h03;
  localparam logic [7:0] TIMING_RST = 8'hFF;
  localparam logic [7:0] BANK_RST = 8'h00;
  // Field positions inside the configuration register.
  localparam int CFG_UPPER_BIT = 5;
  localparam int CFG_MODE_LSB = 2;
  localparam int CFG_ALE_LSB = 0;
  // Field positions inside the timing register.
  localparam int TC_SETUP_LSB = 6;
  localparam int TC_WIDTH_LSB = 2;
  localparam int TC_HOLD_LSB = 0;
  // Fixed cycles added to every access; one goes to the launch cycle.
  localparam logic [4:0] FIXED_CYCLES = 5'h04;
  localparam logic [4:0] LAUNCH_LEN = 5'h01;
  localparam logic [4:0] TAIL_LEN = FIXED_CYCLES - LAUNCH_LEN;
  // Bus configuration modes.
  typedef enum logic [2:0] {
    MODE_INTERNAL = 3'b000,
    MODE_MUX_SPLIT = 3'b001,
    MODE_MUX_BANK = 3'b010,
    MODE_MUX_EXT = 3'b011,
    MODE_NM_INTERNAL = 3'b100,
    MODE_NM_SPLIT = 3'b101,
    MODE_NM_BANK = 3'b110,
    MODE_NM_EXT = 3'b111
  } mode_t;
  // Access sequencer states; every code is used.
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_LAUNCH = 3'b001,
    ST_ALE_HI = 3'b010,
    ST_ALE_LO = 3'b011,
    ST_SETUP = 3'b100,
    ST_STROBE = 3'b101,
    ST_HOLD = 3'b110,
    ST_TAIL = 3'b111
  } state_t;
  // One external-move request from the CPU.
  typedef struct packed {
    logic write;
    logic wide;
    logic [15:0] addr;
    logic [7:0] wdata;
  } req_t;
  // Outputs toward the memory pins.
  typedef struct packed {
    logic [7:0] addr_hi;
    logic addr_hi_oe;
    logic [7:0] addr_lo;
    logic addr_lo_oe;
    logic [7:0] ad;
    logic ad_oe;
    logic ale;
    logic rd_n;
    logic wr_n;
    logic port_upper;
  } pins_t;
  // True for the multiplexed address/data modes.
  function automatic logic mode_is_mux(input logic [2:0] m);
    return (m == MODE_MUX_SPLIT) || (m == MODE_MUX_BANK) || (m == MODE_MUX_EXT);
  endfunction
  // True where byte accesses take the upper address from the bank register.
  function automatic logic mode_uses_bank(input logic [2:0] m);
    return (m == MODE_MUX_BANK) || (m == MODE_NM_BANK);
  endfunction
  // True where off-chip cycles are possible at all.
  function automatic logic mode_offchip(input logic [2:0] m);
    return (m != MODE_INTERNAL) && (m != MODE_NM_INTERNAL);
  endfunction
endpackage

// >>> rtl/sync2.sv
`timescale 1ns/1ns
`default_nettype none
// ****************************************************************
// Two-flop synchroniser for levels from another domain.
// ****************************************************************
module sync2 #(
  parameter int W = 1
) (
  // Clock and asynchronous reset, raw or already synchronised.
  input wire logic clk,
  input wire logic rst_n,
  // Asynchronous input and its synchronised copy.
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg; // First stage, read only by the second.
  logic [W-1:0] q_reg; // Second stage.

  // Both stages clear to zero under reset.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '0;
      q_reg <= '0;
    end else begin
      meta_reg <= d;
      q_reg <= meta_reg;
    end
  end
  assign q = q_reg;
endmodule
`default_nettype wire

// >>> rtl/phase_timer.sv
`timescale 1ns/1ns
`default_nettype none
// ****************************************************************
// Down counter that times one phase of a bus cycle.
// ****************************************************************
module phase_timer (
  // Clock and synchronised reset.
  input wire logic clk,
  input wire logic rst_n,
  // Load strobe and phase length minus one.
  input wire logic load,
  input wire logic [4:0] load_val,
  // High in the last cycle of the phase.
  output logic expired
);
  logic [4:0] cnt_reg; // Cycles left in the phase.
  logic [4:0] cnt_next; // Next count.

  // A load restarts the phase; otherwise count down to zero and stay.
  always_comb begin
    if (load) begin
      cnt_next = load_val;
    end else if (cnt_reg != 5'h00) begin
      cnt_next = cnt_reg - 5'h01;
    end else begin
      cnt_next = cnt_reg;
    end
  end

  // Register the count.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= 5'h00;
    end else begin
      cnt_reg <= cnt_next;
    end
  end
  assign expired = (cnt_reg == 5'h00);
endmodule
`default_nettype wire

// >>> rtl/ext_mem_port.sv
`timescale 1ns/1ns
`default_nettype none
module ext_mem_port
  import ext_mem_pkg::*;
(
  // Clock and reset.
  input wire logic MCLK,
  input wire logic RESET_N,
  // Register port.
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  // External-move requests from the CPU.
  input wire logic XREQ,
  input wire ext_mem_pkg::req_t XREQ_INFO,
  output logic XBUSY,
  output logic XDONE,
  output logic [7:0] XRDATA,
  // Memory pins.
  output ext_mem_pkg::pins_t MEM_PINS,
  input wire logic [7:0] MEM_AD_I
);
  import ext_mem_pkg::*;

  // ****************************************************************
  // Reset release and pin input synchronisation.
  // ****************************************************************
  logic rst_n; // Synchronised reset used by all other logic.
  logic [7:0] ad_sync; // Data pins after two flops.

  // Reset is released through two flops.
  sync2 #(.W(1)) u_rst_sync (
    .clk(MCLK),
    .rst_n(RESET_N),
    .d(1'b1),
    .q(rst_n)
  );

  // Read data from the pins pass two flops before use.
  sync2 #(.W(8)) u_ad_sync (
    .clk(MCLK),
    .rst_n(rst_n),
    .d(MEM_AD_I),
    .q(ad_sync)
  );

  // ****************************************************************
  // Registers.
  // ****************************************************************
  logic [7:0] config_reg, config_next; // Port group, mode and latch width.
  logic [7:0] timing_reg, timing_next; // Setup, strobe width and hold.
  logic [7:0] bank_reg, bank_next; // Upper address for bank-select cycles.
  logic [7:0] rdata_reg, rdata_next; // Register read data.
  state_t state_reg, state_next; // Sequencer state.
  logic busy; // An access is in progress.
  logic [2:0] mode; // Configured bus mode.
  logic [1:0] setup_f, hold_f, ale_f; // Timing fields.
  logic [3:0] width_f; // Strobe width field.

  assign busy = (state_reg != ST_IDLE);
  assign mode = config_reg[CFG_MODE_LSB +: 3];
  assign ale_f = config_reg[CFG_ALE_LSB +: 2];
  assign setup_f = timing_reg[TC_SETUP_LSB +: 2];
  assign width_f = timing_reg[TC_WIDTH_LSB +: 4];
  assign hold_f = timing_reg[TC_HOLD_LSB +: 2];

  // Writes are taken only while idle so a cycle never changes shape midway.
  always_comb begin
    config_next = config_reg;
    timing_next = timing_reg;
    bank_next = bank_reg;
    rdata_next = 8'h00;
    if (REG_WR && !busy) begin
      if (REG_ADDR == ADDR_CONFIG) begin
        config_next = REG_WDATA;
      end else if (REG_ADDR == ADDR_TIMING) begin
        timing_next = REG_WDATA;
      end else if (REG_ADDR == ADDR_BANK) begin
        bank_next = REG_WDATA;
      end
    end
    // Reads answer one cycle later; unmapped addresses read zero.
    if (REG_RD) begin
      unique case (REG_ADDR)
        ADDR_CONFIG: rdata_next = config_reg;
        ADDR_TIMING: rdata_next = timing_reg;
        ADDR_BANK: rdata_next = bank_reg;
        ADDR_STATUS: rdata_next = {4'h0, busy, state_reg};
        default: rdata_next = 8'h00;
      endcase
    end
  end

  // Register the map; timing resets to its longest settings.
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      config_reg <= CONFIG_RST;
      timing_reg <= TIMING_RST;
      bank_reg <= BANK_RST;
      rdata_reg <= 8'h00;
    end else begin
      config_reg <= config_next;
      timing_reg <= timing_next;
      bank_reg <= bank_next;
      rdata_reg <= rdata_next;
    end
  end
  assign REG_RDATA = rdata_reg;

  // ****************************************************************
  // Access sequencer.
  // ****************************************************************
  req_t req_reg, req_next; // Request being served.
  logic expired; // Last cycle of the current phase.
  logic load; // Start timing a new phase.
  logic [4:0] load_val; // New phase length minus one.
  logic [2:0] rpipe_reg, rpipe_next; // Delays the read sample point.
  logic done_reg, done_next; // Completion pulse.
  logic [7:0] xrdata_reg, xrdata_next; // Captured read data.
  state_t after_ale, after_strobe; // Phase successors that may skip.

  // Length in cycles of each timed phase.
  function automatic logic [4:0] phase_len(input state_t s);
    unique case (s)
      ST_ALE_HI, ST_ALE_LO: phase_len = {3'h0, ale_f} + 5'h01;
      ST_SETUP: phase_len = {3'h0, setup_f};
      ST_STROBE: phase_len = {1'b0, width_f} + 5'h01;
      ST_HOLD: phase_len = {3'h0, hold_f};
      ST_TAIL: phase_len = TAIL_LEN;
      ST_IDLE, ST_LAUNCH: phase_len = LAUNCH_LEN;
    endcase
  endfunction

  phase_timer u_timer (
    .clk(MCLK),
    .rst_n(rst_n),
    .load(load),
    .load_val(load_val),
    .expired(expired)
  );

  // Zero-length setup and hold phases are skipped.
  assign after_ale = (setup_f != 2'h0) ? ST_SETUP : ST_STROBE;
  assign after_strobe = (hold_f != 2'h0) ? ST_HOLD : ST_TAIL;

  // Walk the phases; each phase lasts until the timer expires.
  always_comb begin
    state_next = state_reg;
    req_next = req_reg;
    unique case (state_reg)
      ST_IDLE: begin
        // Requests are served only in off-chip modes.
        if (XREQ && mode_offchip(mode)) begin
          state_next = ST_LAUNCH;
          req_next = XREQ_INFO;
        end
      end
      ST_LAUNCH: state_next = mode_is_mux(mode) ? ST_ALE_HI : after_ale;
      ST_ALE_HI: if (expired) state_next = ST_ALE_LO;
      ST_ALE_LO: if (expired) state_next = after_ale;
      ST_SETUP: if (expired) state_next = ST_STROBE;
      ST_STROBE: if (expired) state_next = after_strobe;
      ST_HOLD: if (expired) state_next = ST_TAIL;
      ST_TAIL: if (expired) state_next = ST_IDLE;
    endcase
    load = (state_next != state_reg);
    load_val = phase_len(state_next) - 5'h01;
    // Mark the last strobe cycle of a read and delay it through the sync.
    rpipe_next = {rpipe_reg[1:0],
                  (state_reg == ST_STROBE) && expired && !req_reg.write};
    xrdata_next = rpipe_reg[2] ? ad_sync : xrdata_reg;
    done_next = (state_reg == ST_TAIL) && expired;
  end

  // Register the sequencer.
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      req_reg <= '0;
      rpipe_reg <= 3'h0;
      xrdata_reg <= 8'h00;
      done_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      req_reg <= req_next;
      rpipe_reg <= rpipe_next;
      xrdata_reg <= xrdata_next;
      done_reg <= done_next;
    end
  end
  assign XBUSY = busy;
  assign XDONE = done_reg;
  assign XRDATA = xrdata_reg;

  // ****************************************************************
  // Pin drive.
  // ****************************************************************
  pins_t pins_reg, pins_next; // Registered pin outputs.
  logic mux; // Multiplexed mode.
  logic addr_phase; // Address still on the shared bus.
  logic data_phase; // Write data window.

  assign mux = mode_is_mux(mode);
  assign addr_phase = (state_reg == ST_LAUNCH) || (state_reg == ST_ALE_HI) ||
                      (state_reg == ST_ALE_LO);
  assign data_phase = (state_reg == ST_SETUP) || (state_reg == ST_STROBE) ||
                      (state_reg == ST_HOLD);

  // Pins follow the state one cycle later; all enables drop when idle.
  always_comb begin
    pins_next = '0;
    pins_next.rd_n = 1'b1;
    pins_next.wr_n = 1'b1;
    pins_next.port_upper = config_reg[CFG_UPPER_BIT];
    if (busy) begin
      // Upper address: full address for wide cycles, bank for byte cycles in bank modes, none otherwise.
      if (req_reg.wide) begin
        pins_next.addr_hi = req_reg.addr[15:8];
        pins_next.addr_hi_oe = 1'b1;
      end else if (mode_uses_bank(mode)) begin
        pins_next.addr_hi = bank_reg;
        pins_next.addr_hi_oe = 1'b1;
      end
      if (mux) begin
        // Shared bus carries the low address, then write data.
        if (addr_phase) begin
          pins_next.ad = req_reg.addr[7:0];
          pins_next.ad_oe = 1'b1;
        end else if (data_phase && req_reg.write) begin
          pins_next.ad = req_reg.wdata;
          pins_next.ad_oe = 1'b1;
        end
        pins_next.ale = (state_reg == ST_ALE_HI);
      end else begin
        pins_next.addr_lo = req_reg.addr[7:0];
        pins_next.addr_lo_oe = 1'b1;
        if (data_phase && req_reg.write) begin
          pins_next.ad = req_reg.wdata;
          pins_next.ad_oe = 1'b1;
        end
      end
      if (state_reg == ST_STROBE) begin
        pins_next.rd_n = req_reg.write;
        pins_next.wr_n = !req_reg.write;
      end
    end
  end

  // Register the pins.
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      pins_reg <= '{rd_n: 1'b1, wr_n: 1'b1, default: '0};
    end else begin
      pins_reg <= pins_next;
    end
  end
  assign MEM_PINS = pins_reg;

  // ****************************************************************
  // Assertions and covers.
  // ****************************************************************
  logic [4:0] age_reg; // Cycles spent in the current state.
  logic [5:0] total_reg; // Cycles since launch.

  // Helper counters that only the assertions read.
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      age_reg <= 5'h01;
      total_reg <= 6'h00;
    end else begin
      age_reg <= (state_next != state_reg) ? 5'h01 : age_reg + 5'h01;
      total_reg <= (state_reg == ST_IDLE) ? 6'h00 : total_reg + 6'h01;
    end
  end

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!rst_n);

  setup_len_a: assert property ((state_reg == ST_SETUP && state_next != ST_SETUP) |->
    age_reg == {3'h0, setup_f}) else $error("Setup phase length wrong.");
  strobe_len_a: assert property ((state_reg == ST_STROBE && state_next != ST_STROBE) |->
    age_reg == {1'b0, width_f} + 5'h01) else $error("Strobe length wrong.");
  hold_len_a: assert property ((state_reg == ST_HOLD && state_next != ST_HOLD) |->
    age_reg == {3'h0, hold_f}) else $error("Hold phase length wrong.");
  ale_high_a: assert property ((state_reg == ST_ALE_HI && state_next != ST_ALE_HI) |->
    age_reg == {3'h0, ale_f} + 5'h01) else $error("Latch high length wrong.");
  ale_low_a: assert property ((state_reg == ST_ALE_LO && state_next != ST_ALE_LO) |->
    age_reg == {3'h0, ale_f} + 5'h01) else $error("Latch low length wrong.");
  access_total_a: assert property ((state_reg == ST_TAIL && expired && !mux) |->
    total_reg == {4'h0, setup_f} + {2'h0, width_f} + {4'h0, hold_f} + 6'h04)
    else $error("Access length wrong.");
  mux_total_a: assert property ((state_reg == ST_TAIL && expired && mux) |->
    total_reg == {4'h0, setup_f} + {2'h0, width_f} + {4'h0, hold_f} + 6'h06 +
    {3'h0, ale_f, 1'b0}) else $error("Multiplexed access length wrong.");
  mode_path_a: assert property ((state_reg == ST_LAUNCH) |=>
    ((state_reg == ST_ALE_HI) == mux)) else $error("Mode decode wrong.");
  bank_drive_a: assert property ((busy && !req_reg.wide && mode_uses_bank(mode)) |=>
    (MEM_PINS.addr_hi_oe && MEM_PINS.addr_hi == $past(bank_reg)))
    else $error("Bank address not driven.");
  no_bank_a: assert property ((busy && !req_reg.wide && !mode_uses_bank(mode)) |=>
    !MEM_PINS.addr_hi_oe) else $error("Upper address driven without bank.");
  idle_quiet_a: assert property ((state_reg == ST_IDLE) |=>
    !(MEM_PINS.addr_hi_oe || MEM_PINS.addr_lo_oe || MEM_PINS.ad_oe))
    else $error("Pins driven while idle.");
  wdata_window_a: assert property ((state_reg == ST_STROBE && req_reg.write) |=>
    (MEM_PINS.ad_oe && !MEM_PINS.wr_n)) else $error("Write data missing at strobe.");
  wdata_hold_a: assert property ((state_reg == ST_HOLD && req_reg.write) |=>
    (MEM_PINS.ad_oe && MEM_PINS.wr_n)) else $error("Write data not held.");
  reset_timing_a: assert property ($rose(rst_n) |-> timing_reg == TIMING_RST)
    else $error("Timing not at maximum after reset.");

  mux_read_c: cover property (state_reg == ST_TAIL && mux && !req_reg.write);
  nm_write_c: cover property (state_reg == ST_TAIL && !mux && req_reg.write);
  bank_byte_c: cover property (busy && !req_reg.wide && mode_uses_bank(mode));
endmodule
`default_nettype wire

// >>> dv/ext_mem_model.sv
`timescale 1ns/1ns
`default_nettype none
// ****************************************************************
// Behavioural byte-wide memory on the far side of the port.
// ****************************************************************
module ext_mem_model
  import ext_mem_pkg::*;
(
  // Clock of the bench.
  input wire logic clk,
  // High when the address travels over the shared address/data lines.
  input wire logic mux,
  // Pins from the port and the data lines driven back.
  input wire ext_mem_pkg::pins_t pins,
  output logic [7:0] ad_in
);
  logic [7:0] mem [0:255]; // Storage, keyed by the low address byte.
  logic [7:0] lat_addr = 8'h00; // Low address caught while the latch enable is high.
  logic [7:0] last = 8'h00; // Last value put on the data lines.
  logic [7:0] addr; // Address of the current cycle.
  // Fills the storage with a known pattern.
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'(i);
    end
  end
  // Picks the latched or the direct low address.
  assign addr = mux ? lat_addr : pins.addr_lo;
  // Catches the address, stores written bytes, remembers the last read value.
  always @(posedge clk) begin
    if (pins.ale) begin
      lat_addr <= pins.ad;
    end
    if (!pins.wr_n) begin
      mem[addr] <= pins.ad;
    end
    if (!pins.rd_n) begin
      last <= ad_in;
    end
  end
  // Drives data only while read strobe is low; the lines float to a changed value otherwise.
  assign ad_in = !pins.rd_n ? mem[addr] : ~last;
endmodule
`default_nettype wire

// >>> dv/ext_mem_port_test.sv
`timescale 1ns/1ns
`default_nettype none
// ****************************************************************
// Self-checking bench of the external memory port.
// ****************************************************************
module ext_mem_port_test;
  import ext_mem_pkg::*;
  logic mclk = 1'b0; // Bench clock, 100 MHz.
  logic reset_n = 1'b0; // Raw reset, held low at start.
  logic [7:0] reg_addr = 8'h00; // Register port inputs.
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata; // Register read data.
  logic xreq = 1'b0; // Access request and its details.
  req_t xreq_info = '0;
  logic xbusy, xdone; // Access status.
  logic [7:0] xrdata; // Captured read data.
  pins_t pins; // Memory pins.
  logic [7:0] ad_in; // Data lines from the memory.
  logic mux = 1'b0; // Multiplexed mode in use.
  int error_cnt = 0; // Mismatch count.
  int n_compared = 0; // Comparison count.
  int seed = 32'h2dc2e0ed; // Fixed random seed.
  int strb_n = 0; // Strobe-low cycles of the last access.
  int ale_n = 0; // Latch-enable-high cycles of the last access.
  int busy_n = 0; // Busy cycles of the last access.
  logic hi_seen = 1'b0; // Upper address was driven.
  logic hi_bad = 1'b0; // Upper address had a wrong value.
  logic [7:0] exp_hi = 8'h00; // Expected upper address.
  logic [2:0] modes [6] = '{3'h1, 3'h2, 3'h3, 3'h5, 3'h6, 3'h7}; // Off-chip modes.
  always #5 mclk = ~mclk;
  ext_mem_port u_dut (
    .MCLK(mclk), .RESET_N(reset_n),
    .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
    .REG_RDATA(reg_rdata),
    .XREQ(xreq), .XREQ_INFO(xreq_info), .XBUSY(xbusy), .XDONE(xdone), .XRDATA(xrdata),
    .MEM_PINS(pins), .MEM_AD_I(ad_in)
  );
  ext_mem_model u_mem (.clk(mclk), .mux(mux), .pins(pins), .ad_in(ad_in));
  // ****************************************************************
  // Pin monitor: counts phases, cleared by each new request.
  // ****************************************************************
  always @(posedge mclk) begin
    if (xreq) begin
      strb_n <= 0;
      ale_n <= 0;
      busy_n <= 0;
      hi_seen <= 1'b0;
      hi_bad <= 1'b0;
    end else begin
      if (!pins.rd_n || !pins.wr_n) strb_n <= strb_n + 1;
      if (pins.ale) ale_n <= ale_n + 1;
      if (xbusy) busy_n <= busy_n + 1;
      if (pins.addr_hi_oe) hi_seen <= 1'b1;
      if (pins.addr_hi_oe && pins.addr_hi !== exp_hi) hi_bad <= 1'b1;
    end
  end
  // ****************************************************************
  // Shared tasks.
  // ****************************************************************
  // Compares and reports a mismatch at once.
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  // One-cycle register write.
  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  // One-cycle register read; data taken in the following cycle.
  task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  // One access; returns edges from the taking edge to the done pulse (200 on none).
  task automatic access(input logic wr, input logic wd, input logic [15:0] a,
                        input logic [7:0] d, output int lat);
    @(posedge mclk);
    xreq <= 1'b1;
    xreq_info <= '{write: wr, wide: wd, addr: a, wdata: d};
    @(posedge mclk);
    xreq <= 1'b0;
    lat = 0;
    do begin
      @(posedge mclk);
      #1;
      lat++;
    end while (xdone !== 1'b1 && lat < 200);
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test();
    $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Cuts a hang short.
  initial begin
    #500000;
    error_cnt++;
    stop_test();
  end
  // ****************************************************************
  // Main sequence.
  // ****************************************************************
  initial begin
    logic [7:0] rd, d, bank;
    logic [15:0] a;
    logic [2:0] mode;
    logic wd, up, bankm;
    int lat, s, w, h, al, exp_lat;
    repeat (20) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (4) @(posedge mclk);
    // Reset values and an unmapped address.
    reg_read(ADDR_TIMING, rd); check(32'(rd), 32'(TIMING_RST));
    reg_read(ADDR_CONFIG, rd); check(32'(rd), 32'(CONFIG_RST));
    reg_read(ADDR_BANK, rd); check(32'(rd), 32'(BANK_RST));
    reg_read(8'h10, rd); check(32'(rd), 32'h0);
    reg_read(ADDR_STATUS, rd); check(32'(rd), 32'h0);
    $display("Test reset values done");
    // A request with no off-chip space must leave the pins alone.
    access(1'b0, 1'b1, 16'h1234, 8'h00, lat); check(32'(lat), 32'd200);
    check(32'(hi_seen), 32'h0);
    check(32'(busy_n), 32'h0);
    $display("Test refused request done");
    // Every off-chip mode, shortest and longest timing first, then random.
    foreach (modes[i]) begin
      for (int k = 0; k < 6; k++) begin
        mode = modes[i];
        s = $random(seed) & 3;
        w = $random(seed) & 15;
        h = $random(seed) & 3;
        al = $random(seed) & 3;
        if (k == 0) begin
          s = 0; w = 0; h = 0; al = 0;
        end else if (k == 1) begin
          s = 3; w = 15; h = 3; al = 3;
        end
        up = 1'($random(seed));
        wd = 1'($random(seed));
        a = 16'($random(seed));
        d = 8'($random(seed));
        bank = 8'($random(seed));
        mux = !mode[2];
        bankm = (mode[1:0] == 2'b10);
        exp_hi = wd ? a[15:8] : bank;
        exp_lat = s + w + h + 5 + (mux ? 2 * (al + 1) : 0);
        reg_write(ADDR_CONFIG, {2'b00, up, mode, 2'(al)});
        reg_write(ADDR_TIMING, {2'(s), 4'(w), 2'(h)});
        reg_write(ADDR_BANK, bank);
        // Write then read back the same place.
        for (int r = 1; r >= 0; r--) begin
          access(r[0], wd, a, d, lat); check(32'(lat), 32'(exp_lat));
          check(32'(strb_n), 32'(w + 1));
          check(32'(busy_n), 32'(exp_lat));
          check(32'(xbusy), 32'h0);
          check(32'(ale_n), 32'(mux ? al + 1 : 0));
          check(32'(hi_seen), 32'(wd || bankm));
          check(32'(hi_bad), 32'h0);
          check(32'(pins.port_upper), 32'(up));
          if (r == 0) check(32'(xrdata), 32'(d));
          @(posedge mclk);
          #1;
          check(32'(pins.ad_oe | pins.addr_lo_oe | pins.addr_hi_oe), 32'h0);
        end
      end
      $display("Test mode %0d done", modes[i]);
    end
    stop_test();
  end
endmodule
`default_nettype wire
